// [rtl/i2s_serial_audio_port.sv]
// Serial audio port, master or slave, 16-bit stereo words in both directions.
// Notes on behaviour
// [R1] Bit clock and word select are driven in master mode and are inputs in slave mode; data out is always driven.
// [R2] Every channel word is 16 bits long when sent and when received.
// [R3] The left word's most significant bit sits at the most significant position of the frame.
// [R4] The most significant bit goes out on the falling edge one bit clock after each word select change.
// [R5] Left samples travel while word select is low and right samples while it is high.
// [R6] Data changes on bit clock falling edges and is captured on the following rising edge.
// [R7] As master with a zero divider denominator the frame runs at 48 kHz with 32 or 50 bit clocks per frame.
// [R8] The master bit clock comes from the reference clock through a fractional N over M divider.
// [R9] In slave mode any bit clock up to 3.072 MHz is accepted and the far master stays below it.
// [R10] The master bit clock keeps a near even mark to space ratio with each phase at least 0.35 of the period; its phases differ by up to one reference clock.
// [R11] The far master keeps each bit clock phase longer than 0.35 of its period.
// [R12] As master, word select toggles every 16 or 25 bit clocks and slots past the word carry zero.
`timescale 1ns/10ps
`include "i2s_consts.svh"
module i2s_serial_audio_port (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               master_mode,
  input  wire logic               frame50_sel,
  input  wire i2s_pkg::div_word_t div_num,
  input  wire i2s_pkg::div_word_t div_den,
  input  wire logic               sck_in,
  output wire logic               sck_out,
  output wire logic               sck_oe,
  input  wire logic               ws_in,
  output wire logic               ws_out,
  output wire logic               ws_oe,
  output wire logic               sdo,
  input  wire logic               sdi,
  input  wire i2s_pkg::sample_t   tx_left,
  input  wire i2s_pkg::sample_t   tx_right,
  input  wire logic               tx_valid,
  output wire logic               tx_ready,
  output wire i2s_pkg::sample_t   rx_left,
  output wire i2s_pkg::sample_t   rx_right,
  output wire logic               rx_valid
);
  import i2s_pkg::*;

  frac_div_if div_bus ();

  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic       sck_d_r;
  logic       ws_lat_r;
  logic       sck_r;
  logic       ws_r;
  logic [4:0] half_cnt_r;
  logic [4:0] half_last;
  logic       m_fall;
  logic       m_rise;
  logic       s_fall;
  logic       s_rise;
  logic       fall_ev;
  logic       rise_ev;
  logic       ws_fall;
  logic       ws_rise;
  logic       ws_tx_seen_r;
  logic       tx_load;
  sample_t    tx_word;
  sample_t    tx_shift_r;
  sample_t    tx_hold_r;
  logic [4:0] tx_cnt_r;
  tx_state_t  tx_state_r;
  logic       sdo_r;
  logic       ws_rx_seen_r;
  logic [4:0] rx_cnt_r;
  chan_t      rx_ch_r;
  sample_t    rx_shift_r;
  sample_t    rx_word;
  sample_t    rx_lpend_r;
  sample_t    rx_left_r;
  sample_t    rx_right_r;
  logic       rx_valid_r;
  logic       rx_done;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Divider setup; a zero denominator selects the ratio for the chosen frame size.
  assign div_bus.en  = master_mode;
  assign div_bus.num = (div_den != 16'h0000) ? div_num :
                       (frame50_sel ? `I2S_DIV_N_50 : `I2S_DIV_N_32); // R7
  assign div_bus.den = (div_den != 16'h0000) ? div_den :
                       (frame50_sel ? `I2S_DIV_M_50 : `I2S_DIV_M_32); // R7

  frac_clk_div u_div (
    .clock (clock),
    .rst_n (rst_n),
    .bus   (div_bus)
  );

  // Pin synchronisers for bit clock, word select and data in.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
      sck_d_r    <= 1'b0;
    end else begin
      pin_meta_r <= {sck_in, ws_in, sdi}; // R9
      pin_sync_r <= pin_meta_r;
      sck_d_r    <= pin_sync_r[2]; // R11
    end
  end

  assign s_rise = !master_mode && pin_sync_r[2] && !sck_d_r; // R11
  assign s_fall = !master_mode && !pin_sync_r[2] && sck_d_r; // R11

  // Word select as a receiver sees it at the rising edge, used by the transmit side.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ws_lat_r <= 1'b0;
    end else if (s_rise) begin
      ws_lat_r <= pin_sync_r[1];
    end
  end

  // Master bit clock, toggled on every divider tick.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_r <= 1'b0;
    end else if (!master_mode) begin
      sck_r <= 1'b0;
    end else if (div_bus.tick) begin
      sck_r <= !sck_r; // R10
    end
  end

  assign m_fall    = master_mode && div_bus.tick && sck_r;
  assign m_rise    = master_mode && div_bus.tick && !sck_r;
  assign half_last = (frame50_sel ? `I2S_HALF_BITS_50 : `I2S_HALF_BITS_32) - 5'd1;

  // Master word select, toggled on the falling edge that ends each half frame.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_r <= 5'h00;
      ws_r       <= 1'b0;
    end else if (!master_mode) begin
      half_cnt_r <= 5'h00;
      ws_r       <= 1'b0;
    end else if (m_fall) begin
      if (half_cnt_r >= half_last) begin
        half_cnt_r <= 5'h00; // R12
        ws_r       <= !ws_r; // R7
      end else begin
        half_cnt_r <= half_cnt_r + 5'd1;
      end
    end
  end

  assign fall_ev = m_fall || s_fall;
  assign rise_ev = m_rise || s_rise;
  assign ws_fall = master_mode ? ws_r : ws_lat_r;
  assign ws_rise = master_mode ? ws_r : pin_sync_r[1];

  assign sck_out = sck_r;
  assign ws_out  = ws_r;
  assign sck_oe  = master_mode; // R1
  assign ws_oe   = master_mode; // R1

  // Transmit: a changed word select seen at a falling edge starts the next word.
  assign tx_load  = fall_ev && (ws_fall != ws_tx_seen_r); // R4
  assign tx_ready = tx_load && !ws_fall; // R5
  assign tx_word  = ws_fall ? tx_hold_r : (tx_valid ? tx_left : 16'h0000); // R5

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ws_tx_seen_r <= 1'b0;
      tx_hold_r    <= 16'h0000;
    end else if (fall_ev) begin
      ws_tx_seen_r <= ws_fall;
      if (tx_ready) begin
        tx_hold_r <= tx_valid ? tx_right : 16'h0000;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_r <= 16'h0000;
      tx_cnt_r   <= 5'h00;
      tx_state_r <= TX_PAD;
      sdo_r      <= 1'b0;
    end else if (tx_load) begin
      sdo_r      <= tx_word[15]; // R3
      tx_shift_r <= {tx_word[14:0], 1'b0};
      tx_cnt_r   <= `I2S_WORD_LAST; // R2
      tx_state_r <= TX_SHIFT;
    end else if (fall_ev) begin
      case (tx_state_r)
        TX_SHIFT: begin
          if (tx_cnt_r == 5'h00) begin
            sdo_r      <= 1'b0; // R12
            tx_state_r <= TX_PAD;
          end else begin
            sdo_r      <= tx_shift_r[15]; // R6
            tx_shift_r <= {tx_shift_r[14:0], 1'b0};
            tx_cnt_r   <= tx_cnt_r - 5'd1;
          end
        end
        TX_PAD: begin
          sdo_r <= 1'b0; // R12
        end
        default: begin
          tx_state_r <= TX_PAD;
        end
      endcase
    end
  end

  assign sdo = sdo_r;

  // Receive: sample on rising edges; a word select change restarts the count.
  assign rx_word = {rx_shift_r[14:0], pin_sync_r[0]};
  assign rx_done = rise_ev && (rx_cnt_r == `I2S_WORD_LAST);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r     <= `I2S_WORD_BITS;
      rx_shift_r   <= 16'h0000;
      rx_ch_r      <= CH_LEFT;
      ws_rx_seen_r <= 1'b0;
    end else if (rise_ev) begin
      ws_rx_seen_r <= ws_rise;
      if (rx_cnt_r < `I2S_WORD_BITS) begin
        rx_shift_r <= rx_word; // R6
        rx_cnt_r   <= rx_cnt_r + 5'd1; // R2
      end
      if (ws_rise != ws_rx_seen_r) begin
        rx_cnt_r <= 5'h00; // R4
        rx_ch_r  <= ws_rise ? CH_RIGHT : CH_LEFT; // R5
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_lpend_r <= 16'h0000;
      rx_left_r  <= 16'h0000;
      rx_right_r <= 16'h0000;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (rx_done && (rx_ch_r == CH_LEFT)) begin
        rx_lpend_r <= rx_word; // R3
      end
      if (rx_done && (rx_ch_r == CH_RIGHT)) begin
        rx_left_r  <= rx_lpend_r;
        rx_right_r <= rx_word; // R5
        rx_valid_r <= 1'b1;
      end
    end
  end

  assign rx_left  = rx_left_r;
  assign rx_right = rx_right_r;
  assign rx_valid = rx_valid_r;

  // Helper counters for the checks below.
  logic [4:0] falls_since_ws_r;
  logic [7:0] phase_cnt_r;
  logic [7:0] prev_phase_r;
  logic [1:0] phase_seen_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      falls_since_ws_r <= 5'h01;
    end else if (m_fall && (half_cnt_r >= half_last)) begin
      falls_since_ws_r <= 5'h00;
    end else if (m_fall && (falls_since_ws_r != 5'h1f)) begin
      falls_since_ws_r <= falls_since_ws_r + 5'd1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt_r  <= 8'h00;
      prev_phase_r <= 8'h00;
      phase_seen_r <= 2'h0;
    end else if (!master_mode) begin
      phase_cnt_r  <= 8'h00;
      phase_seen_r <= 2'h0;
    end else if (div_bus.tick) begin
      prev_phase_r <= phase_cnt_r;
      phase_cnt_r  <= 8'h00;
      if (phase_seen_r != 2'h3) begin
        phase_seen_r <= phase_seen_r + 2'd1;
      end
    end else if (phase_cnt_r != `I2S_PHASE_MAX) begin
      phase_cnt_r <= phase_cnt_r + 8'd1;
    end
  end

  sequence s_ws_edge;
    master_mode && m_fall && (half_cnt_r >= half_last);
  endsequence

  sequence s_word_end;
    fall_ev && !tx_load && (tx_state_r == TX_SHIFT) && (tx_cnt_r == 5'h00);
  endsequence

  property p_pin_dir;
    (sck_oe == master_mode) && (ws_oe == master_mode) && (master_mode || (!sck_out && !ws_out));
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong for mode"); // R1

  property p_word_len;
    s_word_end |=> (tx_state_r == TX_PAD) && !sdo;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word not closed after 16 bits"); // R2

  property p_msb_first;
    tx_load |=> (sdo == $past(tx_word[15])) && (tx_cnt_r == 5'd15);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not sent first"); // R3

  property p_msb_delay;
    (master_mode && m_fall) |-> (tx_load == (falls_since_ws_r == 5'h00));
  endproperty
  a_msb_delay: assert property (p_msb_delay) else $error("msb not one bit after ws edge"); // R4

  property p_left_low;
    (tx_ready && tx_valid) |=> (sdo == $past(tx_left[15])) && !ws_fall;
  endproperty
  a_left_low: assert property (p_left_low) else $error("left word taken off ws low"); // R5

  property p_sdo_on_fall;
    !$stable(sdo) |-> $past(fall_ev);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("data changed off a falling edge"); // R6

  property p_rx_on_rise;
    !$stable(rx_shift_r) |-> $past(rise_ev);
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise) else $error("data sampled off a rising edge"); // R6

  property p_half_frame;
    s_ws_edge |=> (ws_r != $past(ws_r)) && (half_cnt_r == 5'h00);
  endproperty
  a_half_frame: assert property (p_half_frame) else $error("ws did not toggle at half frame"); // R12

  property p_duty;
    (master_mode && div_bus.tick && (phase_seen_r == 2'h3)) |->
      ((phase_cnt_r + 8'd1) >= prev_phase_r) && (phase_cnt_r <= (prev_phase_r + 8'd1));
  endproperty
  a_duty: assert property (p_duty) else $error("bit clock phases unequal"); // R10
endmodule

// [rtl/i2s_consts.svh]
// Constants for the serial audio port: frame layout, divider defaults and timing.
`ifndef I2S_CONSTS_SVH
`define I2S_CONSTS_SVH

`define I2S_CLK_HZ          50000000
`define I2S_FRAME_HZ        48000
`define I2S_BCK32_HZ        1536000
`define I2S_BCK50_HZ        2400000
`define I2S_SLV_MAX_BCK_HZ  3072000
`define I2S_MIN_PHASE_PCT   35
`define I2S_WORD_BITS       5'd16
`define I2S_WORD_LAST       5'd15
`define I2S_HALF_BITS_32    5'd16
`define I2S_HALF_BITS_50    5'd25
`define I2S_DIV_N_32        16'h0180
`define I2S_DIV_M_32        16'h186a
`define I2S_DIV_N_50        16'h000c
`define I2S_DIV_M_50        16'h007d
`define I2S_PHASE_MAX       8'hff

`endif

// [rtl/i2s_pkg.sv]
// Types shared by the serial audio port modules.
package i2s_pkg;
  typedef logic [15:0] sample_t;
  typedef logic [15:0] div_word_t;
  typedef enum logic {CH_LEFT, CH_RIGHT} chan_t;
  typedef enum logic [1:0] {TX_PAD, TX_SHIFT} tx_state_t;
endpackage

// [rtl/frac_div_if.sv]
// Connection between the port and its fractional bit clock divider.
`timescale 1ns/10ps
interface frac_div_if;
  logic               en;
  i2s_pkg::div_word_t num;
  i2s_pkg::div_word_t den;
  logic               tick;
  modport src (output en, output num, output den, input tick);
  modport div (input en, input num, input den, output tick);
endinterface

// [rtl/frac_clk_div.sv]
// Fractional N/M divider giving one enable pulse per bit clock half period.
`timescale 1ns/10ps
`include "i2s_consts.svh"
module frac_clk_div (
  input wire logic clock,
  input wire logic rst_n,
  frac_div_if.div  bus
);
  import i2s_pkg::*;

  logic [16:0] acc_r;
  logic [16:0] sum;
  logic        wrap;
  logic        tick_r;

  assign sum  = acc_r + {1'b0, bus.num};
  assign wrap = (sum >= {1'b0, bus.den}) && (bus.den != 16'h0000);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r  <= 17'h00000;
      tick_r <= 1'b0;
    end else if (!bus.en) begin
      acc_r  <= 17'h00000;
      tick_r <= 1'b0;
    end else if (wrap) begin
      acc_r  <= sum - {1'b0, bus.den}; // R8
      tick_r <= 1'b1;
    end else begin
      acc_r  <= sum;
      tick_r <= 1'b0;
    end
  end

  assign bus.tick = tick_r;

  property p_div_sparse;
    @(posedge clock) disable iff (!rst_n)
      (bus.en && ({bus.num, 1'b0} <= {1'b0, bus.den}) && tick_r) |=> !tick_r;
  endproperty
  a_div_sparse: assert property (p_div_sparse) else $error("divider ticked twice in a row"); // R8
endmodule

// [sim/audio_codec_model.sv]
// Far side codec model: bit clock source in slave mode, serial word source and sink.
`timescale 1ns/10ps
module audio_codec_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        drive_clk,
  input  wire logic [4:0]  half_bits,
  input  wire logic        sck_line,
  input  wire logic        ws_line,
  input  wire logic        sd_from_port,
  output logic             sck_gen,
  output logic             ws_gen,
  output logic             sd_to_port,
  output logic             rpt_stb,
  output logic [16:0]      rpt_word,
  output logic             pair_stb,
  output logic [31:0]      pair_word,
  output logic             pad_err
);
  logic        sck_q, ws_q, ws_r, act, got_l;
  logic [15:0] t, w, l_w, nw;
  logic [4:0]  n, b, ph;
  wire         fall = sck_q & ~sck_line;
  wire         rise = ~sck_q & sck_line;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {sck_q, ws_q, ws_r, act, got_l, sck_gen, ws_gen, sd_to_port} <= '0;
      {rpt_stb, pair_stb, pad_err, rpt_word, pair_word, t, w, l_w, n, b, ph} <= '0;
    end else begin
      sck_q <= sck_line;
      rpt_stb <= 1'b0;
      pair_stb <= 1'b0;
      pad_err <= 1'b0;
      if (drive_clk) begin
        ph <= (ph == 5'd16) ? 5'd0 : ph + 5'd1;
        if (ph == 5'd0) sck_gen <= 1'b1;
        if (ph == 5'd9) begin
          sck_gen <= 1'b0;
          b <= (b == half_bits - 5'd1) ? 5'd0 : b + 5'd1;
          if (b == half_bits - 5'd1) ws_gen <= ~ws_gen;
        end
      end
      if (fall) begin
        sd_to_port <= t[15];
        ws_q <= ws_line;
        if (ws_line != ws_q) begin
          nw = 16'($urandom);
          t <= nw;
          if (ws_line) begin
            pair_stb <= got_l;
            pair_word <= {l_w, nw};
          end else begin
            l_w <= nw;
            got_l <= 1'b1;
          end
        end else t <= {t[14:0], 1'b0};
      end
      if (rise) begin
        if (ws_line != ws_r) begin
          if (act && n == 5'd15) rpt_stb <= 1'b1;
          rpt_word <= {ws_r, w[14:0], sd_from_port};
          if (n == 5'd16 && sd_from_port) pad_err <= 1'b1;
          n <= 5'd0;
          act <= 1'b1;
          ws_r <= ws_line;
        end else if (act && n < 5'd16) begin
          w <= {w[14:0], sd_from_port};
          n <= n + 5'd1;
          rpt_stb <= (n == 5'd15);
          rpt_word <= {ws_r, w[14:0], sd_from_port};
        end else if (act && sd_from_port) pad_err <= 1'b1;
      end
    end
  end
endmodule

// [sim/test_i2s_serial_audio_port.sv]
// Self-checking bench for the serial audio port against a codec model.
`timescale 1ns/10ps
module test_i2s_serial_audio_port;
  import i2s_pkg::*;
  logic        clock = 0, rst_n = 0, master_mode = 1, frame50_sel = 0, tx_valid = 0;
  div_word_t   div_num = '0, div_den = '0;
  sample_t     tx_left = '0, tx_right = '0, rx_left, rx_right;
  logic        sck_out, sck_oe, ws_out, ws_oe, sdo, tx_ready, rx_valid;
  logic        sck_gen, ws_gen, sd_in, rpt_stb, pair_stb, pad_err;
  logic [16:0] rpt_word;
  logic [31:0] pair_word;
  logic [4:0]  half_bits = 5'd16;
  logic [16:0] tx_q[$];
  logic [31:0] rx_q[$];
  int          mismatches = 0, samples_checked = 0;
  wire         sck_line = sck_oe ? sck_out : sck_gen;
  wire         ws_line = ws_oe ? ws_out : ws_gen;
  always #10 clock = ~clock;
  i2s_serial_audio_port i2s_serial_audio_port_inst (
    .clock(clock), .rst_n(rst_n), .master_mode(master_mode), .frame50_sel(frame50_sel),
    .div_num(div_num), .div_den(div_den), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe(sck_oe), .ws_in(ws_line), .ws_out(ws_out), .ws_oe(ws_oe), .sdo(sdo),
    .sdi(sd_in), .tx_left(tx_left), .tx_right(tx_right), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_left(rx_left), .rx_right(rx_right), .rx_valid(rx_valid));
  audio_codec_model audio_codec_model_inst (
    .clock(clock), .rst_n(rst_n), .drive_clk(~master_mode), .half_bits(half_bits),
    .sck_line(sck_line), .ws_line(ws_line), .sd_from_port(sdo), .sck_gen(sck_gen),
    .ws_gen(ws_gen), .sd_to_port(sd_in), .rpt_stb(rpt_stb), .rpt_word(rpt_word),
    .pair_stb(pair_stb), .pair_word(pair_word), .pad_err(pad_err));
  task summarize;
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task fail(input string s);
    mismatches++;
    $display("Error %0t %s", $time, s);
  endtask
  task check_tx(input logic [16:0] g, input logic [16:0] e);
    samples_checked++;
    if (g !== e) fail("tx word differs");
  endtask
  task check_rx(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) fail("rx pair differs");
  endtask
  task check_num(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) fail("value differs");
  endtask
  task wait_ws(input logic v, output int c);
    c = 0;
    while (ws_out !== v) begin
      @(posedge clock);
      #1;
      c++;
      if (c > 3000) begin
        fail("word select stuck");
        summarize();
      end
    end
  endtask
  task run(input logic m, input logic f, input div_word_t dn, input div_word_t dd,
           input logic [4:0] hb, input int lo, input int hi);
    int c0, c1, k;
    @(posedge clock);
    #1 rst_n = 0;
    master_mode = m;
    frame50_sel = f;
    div_num = dn;
    div_den = dd;
    half_bits = hb;
    tx_left = sample_t'($urandom);
    tx_right = sample_t'($urandom);
    tx_q.delete();
    rx_q.delete();
    repeat (2) @(posedge clock);
    #1 rst_n = 1;
    tx_valid = 1;
    check_num(sck_oe, m);
    check_num(ws_oe, m);
    k = 0;
    for (int i = 0; i < 20000 && k < 6; i++) begin
      @(posedge clock);
      if (rx_valid === 1'b1) k++;
    end
    if (k < 6) begin
      fail("no receive pulse");
      summarize();
    end
    if (m) begin
      wait_ws(0, c0);
      wait_ws(1, c0);
      wait_ws(0, c0);
      wait_ws(1, c1);
      check_num(c0 + c1 >= lo && c0 + c1 <= hi, 1);
    end
    #1;
  endtask
  always @(posedge clock) begin
    if (rst_n === 1'b1 && tx_ready === 1'b1) begin
      tx_q.push_back({CH_LEFT, tx_valid ? tx_left : 16'h0000});
      tx_q.push_back({CH_RIGHT, tx_valid ? tx_right : 16'h0000});
      #1;
      tx_valid = tx_valid ? ($urandom % 4 != 0) : 1'b1;
      tx_left = sample_t'($urandom);
      tx_right = sample_t'($urandom);
    end
  end
  always @(posedge clock) begin
    if (rpt_stb === 1'b1 && tx_q.size() > 0) check_tx(rpt_word, tx_q.pop_front());
    if (rx_valid === 1'b1 && rx_q.size() > 0) check_rx({rx_left, rx_right}, rx_q.pop_front());
    if (pad_err === 1'b1) check_num(1, 0);
    if (pair_stb === 1'b1) rx_q.push_back(pair_word);
  end
  initial begin
    void'($urandom(35));
    run(1, 0, 16'h0001, 16'h0008, 5'd16, 512, 512);
    run(1, 1, 16'h0001, 16'h0008, 5'd16, 800, 800);
    run(1, 0, 16'h0000, 16'h0000, 5'd16, 1041, 1042);
    run(1, 1, 16'h0000, 16'h0000, 5'd16, 1041, 1042);
    run(0, 0, 16'h0000, 16'h0000, 5'd16, 0, 0);
    run(0, 1, 16'h0000, 16'h0000, 5'd20, 0, 0);
    summarize();
  end
endmodule
